/* hw/atg_pkg.sv */
package atg_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TMR_W         = 9;
  localparam int CNT_W         = 16;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;

  // Scan marker high time, about 4 us
  localparam int SCAN_MARK_NS   = 4000;
  localparam int SCAN_MARK_CYC_I = (SCAN_MARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe low time, a least time, so round up
  localparam int STROBE_MIN_NS  = 500;
  localparam int STROBE_CYC_I   = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time from a convert falling edge to hold, rounded down
  localparam int HOLD_MAX_NS    = 100;
  localparam int HOLD_MAX_CYC   = HOLD_MAX_NS / CLK_PERIOD_NS;
  // Longest time from an update trigger falling edge to the update, rounded down
  localparam int DAC_UPD_MAX_NS = 100;
  localparam int DAC_UPD_MAX_CYC = DAC_UPD_MAX_NS / CLK_PERIOD_NS;
  // Low time driven on the shared convert net by the interval counter
  localparam int CONV_DRIVE_NS  = 100;
  localparam int CONV_DRIVE_CYC_I = (CONV_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [TMR_W-1:0] SCAN_MARK_CYC  = TMR_W'(SCAN_MARK_CYC_I);
  localparam logic [TMR_W-1:0] STROBE_CYC     = TMR_W'(STROBE_CYC_I);
  localparam logic [TMR_W-1:0] CONV_DRIVE_CYC = TMR_W'(CONV_DRIVE_CYC_I);
  localparam logic [TMR_W-1:0] TMR_ZERO       = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE        = 16'h0001;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SCOUNT   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INTERVAL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STROBE   = 8'h14;

  // Control register fields
  localparam int CTRL_SCAN_EN     = 0;
  localparam int CTRL_PRETRIG     = 1;
  localparam int CTRL_TRIG_IGNORE = 2;
  localparam int CTRL_SOFT_GATE   = 3;
  localparam int CTRL_INT_PACE    = 4;
  localparam int CTRL_DAC_SRC     = 5;
  localparam int CTRL_DAC_WAVE    = 6;
  localparam int CTRL_W           = 7;

  // Command register fields
  localparam int CMD_START = 0;
  localparam int CMD_ABORT = 1;

  // Status register fields
  localparam int ST_ACTIVE    = 0;
  localparam int ST_PRETRIG   = 1;
  localparam int ST_GATE      = 2;
  localparam int ST_TRIG      = 3;
  localparam int ST_COUNT_LSB = 16;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST     = 7'h00;
  localparam logic [CNT_W-1:0]  SCOUNT_RST   = 16'h0001;
  localparam logic [CNT_W-1:0]  INTERVAL_RST = 16'h0064;

  // Synchronised input lanes
  localparam int SYN_TRIG = 0;
  localparam int SYN_GATE = 1;
  localparam int SYN_CONV = 2;
  localparam int SYN_DAC  = 3;
  localparam int SYN_N    = 4;
  localparam logic [SYN_N-1:0] SYN_IDLE = 4'hf;

  typedef enum logic [1:0] {
    ACQ_IDLE,
    ACQ_PRE,
    ACQ_RUN
  } atg_acq_e;

endpackage : atg_pkg

/* hw/atg_edge_sync.sv */
`timescale 1ns/1ps
module atg_edge_sync (
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  input  wire logic [atg_pkg::SYN_N-1:0] asyncIn,
  output logic      [atg_pkg::SYN_N-1:0] level,
  output logic      [atg_pkg::SYN_N-1:0] fall
);

  typedef struct packed {
    logic [atg_pkg::SYN_N-1:0] meta;
    logic [atg_pkg::SYN_N-1:0] sync;
    logic [atg_pkg::SYN_N-1:0] prev;
  } atg_sync_s;

  atg_sync_s st;
  atg_sync_s next_st;

  // R20 two-stage sync
  always_comb begin
    next_st      = st;
    next_st.meta = asyncIn;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  // Inputs idle high, so reset to high to avoid a false edge at release
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st <= '{meta: atg_pkg::SYN_IDLE, sync: atg_pkg::SYN_IDLE, prev: atg_pkg::SYN_IDLE};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.sync;
  // R20 edge from synced
  assign fall  = st.prev & ~st.sync;

  property p_fall_pulse;
    @(posedge clk_sys) disable iff (!reset_n)
      fall[atg_pkg::SYN_TRIG] |=> !fall[atg_pkg::SYN_TRIG];
  endproperty
  a_fall_pulse: assert property (p_fall_pulse) // R20
    else $error("edge pulse lasted more than one cycle");

endmodule : atg_edge_sync

/* hw/atg_timing.sv */
`timescale 1ns/1ps
// Function
// R1 - Scan marker rises at the start of every conversion.
// R2 - Scan marker pulses only while scanning is enabled, low otherwise.
// R3 - Each scan marker pulse stays high about 4 us.
// R4 - Strobe register access emits one low latch pulse of at least 500 ns.
// R5 - Each low pulse on the convert request input starts one conversion.
// R6 - External convert pulses stay low at least 50 ns.
// R7 - External convert input stays high one conversion period between pulses.
// R8 - Converter enters hold within 100 ns of a convert falling edge.
// R9 - Interval counter drives the shared convert net only when pacing internally.
// R10 - No conversions outside a sequence or when either gate blocks.
// R11 - Trigger falling edge starts sample and interval counters.
// R12 - Pretrigger acquires after first edge, counts after second, ends at zero.
// R13 - First conversion comes within one sample interval of the trigger.
// R14 - External trigger stays high at least 50 ns before each falling edge.
// R15 - Internal start is ANDed with the trigger input level.
// R16 - A control setting ignores the external trigger input.
// R17 - Gate input low blocks conversions; high lets them proceed.
// R18 - External update trigger updates outputs only when selected and mode matches.
// R19 - Output update follows the trigger falling edge within 100 ns.
// R20 - External inputs are synchronised and edges taken from synced samples.
module atg_timing (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire logic [atg_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [atg_pkg::DATA_W-1:0] pwdata,
  output logic                            pready,
  output logic      [atg_pkg::DATA_W-1:0] prdata,
  output logic                            pslverr,
  input  wire logic                       acquisitionTriggerIn,
  input  wire logic                       conversionGateIn,
  input  wire logic                       convertRequestIn,
  output logic                            convertRequestOut,
  output logic                            convertRequestOeN,
  input  wire logic                       dacUpdateTriggerIn,
  output logic                            scanConversionMarker,
  output logic                            outboundLatchPulseN,
  output logic                            adcHoldStart,
  output logic                            dacUpdateStrobe
);

  typedef struct packed {
    atg_pkg::atg_acq_e                 acq;
    logic [atg_pkg::CTRL_W-1:0]        ctrl;
    logic [atg_pkg::CNT_W-1:0]         sampleLoad;
    logic [atg_pkg::CNT_W-1:0]         intervalLoad;
    logic [atg_pkg::CNT_W-1:0]         sampleCount;
    logic [atg_pkg::CNT_W-1:0]         intervalCount;
    logic [atg_pkg::TMR_W-1:0]         scanTimer;
    logic [atg_pkg::TMR_W-1:0]         strobeTimer;
    logic [atg_pkg::TMR_W-1:0]         convTimer;
    logic                              scanMarker;
    logic                              strobeN;
    logic                              convDrive;
    logic                              convOeN;
    logic                              holdStart;
    logic                              dacUpdate;
    logic                              ready;
    logic                              slvErr;
    logic [atg_pkg::DATA_W-1:0]        rdata;
  } atg_state_s;

  localparam int HOLD_WIN = atg_pkg::HOLD_MAX_CYC;
  localparam int DAC_WIN  = atg_pkg::DAC_UPD_MAX_CYC;

  atg_state_s                 st;
  atg_state_s                 next_st;
  logic [atg_pkg::SYN_N-1:0]  syncLevel;
  logic [atg_pkg::SYN_N-1:0]  syncFall;
  logic                       apbAccess;
  logic                       apbDone;
  logic                       regWrite;
  logic                       startCmd;
  logic                       abortCmd;
  logic                       trigFall;
  logic                       acqStart;
  logic                       convAllowed;
  logic                       intervalTick;
  logic                       convert_request_in;
  logic                       convStart;
  logic                       strobeAccess;
  logic [atg_pkg::DATA_W-1:0] statusWord;

  function automatic logic hit(input logic [atg_pkg::ADDR_W-1:0] a,
                               input logic [atg_pkg::ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  function automatic logic [atg_pkg::TMR_W-1:0] tick(input logic [atg_pkg::TMR_W-1:0] t);
    return (t == atg_pkg::TMR_ZERO) ? atg_pkg::TMR_ZERO : t - 9'h001;
  endfunction : tick

  atg_edge_sync u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .asyncIn ({dacUpdateTriggerIn, convertRequestIn, conversionGateIn, acquisitionTriggerIn}),
    .level   (syncLevel),
    .fall    (syncFall)
  );

  // First access cycle registers the answer, second completes it
  assign apbAccess    = psel & penable & !st.ready;
  assign apbDone      = psel & penable & st.ready;
  assign regWrite     = apbDone & pwrite;
  assign startCmd     = regWrite & hit(paddr, atg_pkg::OFF_CMD) & pwdata[atg_pkg::CMD_START];
  assign abortCmd     = regWrite & hit(paddr, atg_pkg::OFF_CMD) & pwdata[atg_pkg::CMD_ABORT];
  // R4 any access strobes
  assign strobeAccess = apbDone & hit(paddr, atg_pkg::OFF_STROBE);

  // R16 trigger ignore
  assign trigFall = syncFall[atg_pkg::SYN_TRIG] & !st.ctrl[atg_pkg::CTRL_TRIG_IGNORE];
  // R11 R15 start when trigger edge or internal start with line high
  assign acqStart = (st.acq == atg_pkg::ACQ_IDLE) &
                    (trigFall | (startCmd & syncLevel[atg_pkg::SYN_TRIG]));

  // R10 R17 sequence and gates
  assign convAllowed = (st.acq != atg_pkg::ACQ_IDLE) & syncLevel[atg_pkg::SYN_GATE] &
                       !st.ctrl[atg_pkg::CTRL_SOFT_GATE];
  // R13 interval expiry paces internally
  assign intervalTick = (st.acq != atg_pkg::ACQ_IDLE) & st.ctrl[atg_pkg::CTRL_INT_PACE] &
                        (st.intervalCount <= atg_pkg::CNT_ONE);
  // R5 R9 external pacing only when the counter is off the net
  assign convert_request_in   = !st.ctrl[atg_pkg::CTRL_INT_PACE] & syncFall[atg_pkg::SYN_CONV];
  assign convStart = convAllowed & (intervalTick | convert_request_in);

  always_comb begin
    statusWord = '0;
    statusWord[atg_pkg::ST_ACTIVE]  = st.acq != atg_pkg::ACQ_IDLE;
    statusWord[atg_pkg::ST_PRETRIG] = st.acq == atg_pkg::ACQ_PRE;
    statusWord[atg_pkg::ST_GATE]    = syncLevel[atg_pkg::SYN_GATE];
    statusWord[atg_pkg::ST_TRIG]    = syncLevel[atg_pkg::SYN_TRIG];
    statusWord[atg_pkg::ST_COUNT_LSB +: atg_pkg::CNT_W] = st.sampleCount;
  end

  always_comb begin
    next_st           = st;
    next_st.holdStart = 1'b0;
    next_st.dacUpdate = 1'b0;
    next_st.ready     = 1'b0;
    next_st.slvErr    = 1'b0;

    if (apbAccess) begin
      next_st.ready = 1'b1;
      next_st.rdata = '0;
      if (hit(paddr, atg_pkg::OFF_CTRL)) begin
        next_st.rdata[atg_pkg::CTRL_W-1:0] = st.ctrl;
      end else if (hit(paddr, atg_pkg::OFF_SCOUNT)) begin
        next_st.rdata[atg_pkg::CNT_W-1:0] = st.sampleLoad;
      end else if (hit(paddr, atg_pkg::OFF_INTERVAL)) begin
        next_st.rdata[atg_pkg::CNT_W-1:0] = st.intervalLoad;
      end else if (hit(paddr, atg_pkg::OFF_STATUS)) begin
        next_st.rdata = statusWord;
      end else if (!hit(paddr, atg_pkg::OFF_CMD) && !hit(paddr, atg_pkg::OFF_STROBE)) begin
        next_st.slvErr = 1'b1;
      end
    end

    if (regWrite && hit(paddr, atg_pkg::OFF_CTRL)) begin
      next_st.ctrl = pwdata[atg_pkg::CTRL_W-1:0];
    end
    if (regWrite && hit(paddr, atg_pkg::OFF_SCOUNT)) begin
      next_st.sampleLoad = pwdata[atg_pkg::CNT_W-1:0];
    end
    if (regWrite && hit(paddr, atg_pkg::OFF_INTERVAL)) begin
      next_st.intervalLoad = pwdata[atg_pkg::CNT_W-1:0];
    end

    // R13 interval counter reloads each period
    if (st.acq != atg_pkg::ACQ_IDLE) begin
      next_st.intervalCount = (st.intervalCount <= atg_pkg::CNT_ONE) ?
                              st.intervalLoad : st.intervalCount - atg_pkg::CNT_ONE;
    end

    case (st.acq)
      atg_pkg::ACQ_IDLE: begin
        // R11 load both counters
        if (acqStart) begin
          next_st.sampleCount   = st.sampleLoad;
          next_st.intervalCount = st.intervalLoad;
          next_st.acq = st.ctrl[atg_pkg::CTRL_PRETRIG] ? atg_pkg::ACQ_PRE : atg_pkg::ACQ_RUN;
        end
      end
      atg_pkg::ACQ_PRE: begin
        // R12 second edge starts counting
        if (abortCmd) begin
          next_st.acq = atg_pkg::ACQ_IDLE;
        end else if (trigFall) begin
          next_st.acq = atg_pkg::ACQ_RUN;
        end
      end
      atg_pkg::ACQ_RUN: begin
        // R12 ends at zero
        if (abortCmd) begin
          next_st.acq = atg_pkg::ACQ_IDLE;
        end else if (convStart) begin
          if (st.sampleCount <= atg_pkg::CNT_ONE) begin
            next_st.sampleCount = '0;
            next_st.acq         = atg_pkg::ACQ_IDLE;
          end else begin
            next_st.sampleCount = st.sampleCount - atg_pkg::CNT_ONE;
          end
        end
      end
      default: begin
        next_st.acq = atg_pkg::ACQ_IDLE;
      end
    endcase

    // R8 hold request one cycle after the synced edge
    next_st.holdStart = convStart;

    // R1 R2 R3 marker timer, forced low when scanning is off
    if (!st.ctrl[atg_pkg::CTRL_SCAN_EN]) begin
      next_st.scanTimer = atg_pkg::TMR_ZERO;
    end else if (convStart) begin
      next_st.scanTimer = atg_pkg::SCAN_MARK_CYC;
    end else begin
      next_st.scanTimer = tick(st.scanTimer);
    end
    next_st.scanMarker = next_st.scanTimer != atg_pkg::TMR_ZERO;

    // R4 restarting keeps a single pulse at least the full width
    next_st.strobeTimer = strobeAccess ? atg_pkg::STROBE_CYC : tick(st.strobeTimer);
    next_st.strobeN     = next_st.strobeTimer == atg_pkg::TMR_ZERO;

    // R9 counter drives the net low only when pacing internally
    if (!next_st.ctrl[atg_pkg::CTRL_INT_PACE]) begin
      next_st.convTimer = atg_pkg::TMR_ZERO;
    end else if (intervalTick && convAllowed) begin
      next_st.convTimer = atg_pkg::CONV_DRIVE_CYC;
    end else begin
      next_st.convTimer = tick(st.convTimer);
    end
    next_st.convDrive = next_st.convTimer == atg_pkg::TMR_ZERO;
    next_st.convOeN   = !next_st.ctrl[atg_pkg::CTRL_INT_PACE];

    // R18 R19 update on the synced falling edge
    next_st.dacUpdate = syncFall[atg_pkg::SYN_DAC] & !st.ctrl[atg_pkg::CTRL_DAC_SRC] &
                        st.ctrl[atg_pkg::CTRL_DAC_WAVE];
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st.acq           <= atg_pkg::ACQ_IDLE;
      st.ctrl          <= atg_pkg::CTRL_RST;
      st.sampleLoad    <= atg_pkg::SCOUNT_RST;
      st.intervalLoad  <= atg_pkg::INTERVAL_RST;
      st.sampleCount   <= '0;
      st.intervalCount <= '0;
      st.scanTimer     <= atg_pkg::TMR_ZERO;
      st.strobeTimer   <= atg_pkg::TMR_ZERO;
      st.convTimer     <= atg_pkg::TMR_ZERO;
      st.scanMarker    <= 1'b0;
      st.strobeN       <= 1'b1;
      st.convDrive     <= 1'b1;
      st.convOeN       <= 1'b1;
      st.holdStart     <= 1'b0;
      st.dacUpdate     <= 1'b0;
      st.ready         <= 1'b0;
      st.slvErr        <= 1'b0;
      st.rdata         <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pready               = st.ready;
  assign prdata               = st.rdata;
  assign pslverr              = st.slvErr;
  assign convertRequestOut    = st.convDrive;
  assign convertRequestOeN    = st.convOeN;
  assign scanConversionMarker = st.scanMarker;
  assign outboundLatchPulseN  = st.strobeN;
  assign adcHoldStart         = st.holdStart;
  assign dacUpdateStrobe      = st.dacUpdate;

  // Helper counters for pulse widths longer than a repetition can express
  logic [atg_pkg::CNT_W-1:0] scanHighCnt;
  logic [atg_pkg::CNT_W-1:0] strobeLowCnt;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      scanHighCnt  <= '0;
      strobeLowCnt <= '0;
    end else begin
      scanHighCnt  <= (scanConversionMarker && !convStart) ? scanHighCnt + atg_pkg::CNT_ONE : '0;
      strobeLowCnt <= !outboundLatchPulseN ? strobeLowCnt + atg_pkg::CNT_ONE : '0;
    end
  end

  property p_scan_rise;
    @(posedge clk_sys) disable iff (!reset_n)
      convStart && st.ctrl[atg_pkg::CTRL_SCAN_EN] |=> scanConversionMarker;
  endproperty
  a_scan_rise: assert property (p_scan_rise) // R1
    else $error("scan marker not high after conversion start");

  property p_scan_off;
    @(posedge clk_sys) disable iff (!reset_n)
      scanConversionMarker |-> $past(st.ctrl[atg_pkg::CTRL_SCAN_EN]);
  endproperty
  a_scan_off: assert property (p_scan_off) // R2
    else $error("scan marker high while scanning disabled");

  property p_scan_width;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(scanConversionMarker) && $past(st.ctrl[atg_pkg::CTRL_SCAN_EN])
        |-> scanHighCnt == 16'(atg_pkg::SCAN_MARK_CYC_I);
  endproperty
  a_scan_width: assert property (p_scan_width) // R3
    else $error("scan marker width wrong");

  property p_strobe_start;
    @(posedge clk_sys) disable iff (!reset_n)
      strobeAccess |=> !outboundLatchPulseN [*8];
  endproperty
  a_strobe_start: assert property (p_strobe_start) // R4
    else $error("strobe access gave no low pulse");

  property p_strobe_width;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(outboundLatchPulseN) |-> strobeLowCnt >= 16'(atg_pkg::STROBE_CYC_I);
  endproperty
  a_strobe_width: assert property (p_strobe_width) // R4
    else $error("latch pulse shorter than minimum");

  property p_ext_conv;
    @(posedge clk_sys) disable iff (!reset_n)
      convert_request_in && convAllowed |=> adcHoldStart;
  endproperty
  a_ext_conv: assert property (p_ext_conv) // R5
    else $error("convert request pulse started no conversion");

  property p_hold_delay;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(convertRequestIn) && !st.ctrl[atg_pkg::CTRL_INT_PACE] && convAllowed &&
      conversionGateIn |-> ##[1:HOLD_WIN] adcHoldStart;
  endproperty
  a_hold_delay: assert property (p_hold_delay) // R8
    else $error("hold not reached within the allowed time");

  property p_net_drive;
    @(posedge clk_sys) disable iff (!reset_n)
      !convertRequestOut |-> !convertRequestOeN && $past(st.ctrl[atg_pkg::CTRL_INT_PACE]);
  endproperty
  a_net_drive: assert property (p_net_drive) // R9
    else $error("convert net driven while paced externally");

  property p_conv_gated;
    @(posedge clk_sys) disable iff (!reset_n)
      adcHoldStart |-> $past(convAllowed);
  endproperty
  a_conv_gated: assert property (p_conv_gated) // R10
    else $error("conversion outside sequence or while gated");

  property p_gate_low;
    @(posedge clk_sys) disable iff (!reset_n)
      !syncLevel[atg_pkg::SYN_GATE] |=> !adcHoldStart;
  endproperty
  a_gate_low: assert property (p_gate_low) // R17
    else $error("conversion while gate input low");

  property p_trig_start;
    @(posedge clk_sys) disable iff (!reset_n)
      st.acq == atg_pkg::ACQ_IDLE && trigFall |=> st.acq != atg_pkg::ACQ_IDLE;
  endproperty
  a_trig_start: assert property (p_trig_start) // R11
    else $error("trigger edge did not start acquisition");

  property p_pretrig_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      st.acq == atg_pkg::ACQ_PRE |=> $stable(st.sampleCount);
  endproperty
  a_pretrig_hold: assert property (p_pretrig_hold) // R12
    else $error("sample count moved before second trigger");

  property p_int_start_and;
    @(posedge clk_sys) disable iff (!reset_n)
      st.acq == atg_pkg::ACQ_IDLE && !syncLevel[atg_pkg::SYN_TRIG] && !trigFall
        |=> st.acq == atg_pkg::ACQ_IDLE;
  endproperty
  a_int_start_and: assert property (p_int_start_and) // R15
    else $error("sequence started while trigger line low");

  property p_trig_ignore;
    @(posedge clk_sys) disable iff (!reset_n)
      st.acq == atg_pkg::ACQ_IDLE && st.ctrl[atg_pkg::CTRL_TRIG_IGNORE] && !startCmd
        |=> st.acq == atg_pkg::ACQ_IDLE;
  endproperty
  a_trig_ignore: assert property (p_trig_ignore) // R16
    else $error("ignored trigger started a sequence");

  property p_dac_select;
    @(posedge clk_sys) disable iff (!reset_n)
      dacUpdateStrobe |-> $past(!st.ctrl[atg_pkg::CTRL_DAC_SRC] && st.ctrl[atg_pkg::CTRL_DAC_WAVE]);
  endproperty
  a_dac_select: assert property (p_dac_select) // R18
    else $error("output update while not selected");

  property p_dac_delay;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(dacUpdateTriggerIn) && !st.ctrl[atg_pkg::CTRL_DAC_SRC] &&
      st.ctrl[atg_pkg::CTRL_DAC_WAVE] |-> ##[1:DAC_WIN] dacUpdateStrobe;
  endproperty
  a_dac_delay: assert property (p_dac_delay) // R19
    else $error("output update late after trigger edge");

  c_ext_conv: cover property (@(posedge clk_sys) disable iff (!reset_n) convert_request_in && convAllowed);
  c_pre_run: cover property (@(posedge clk_sys) disable iff (!reset_n)
    st.acq == atg_pkg::ACQ_PRE ##1 st.acq == atg_pkg::ACQ_RUN);
  c_strobe: cover property (@(posedge clk_sys) disable iff (!reset_n) strobeAccess);
  c_dac: cover property (@(posedge clk_sys) disable iff (!reset_n) dacUpdateStrobe);

endmodule : atg_timing

/* tb/atg_ext_source.sv */
`timescale 1ns/1ps
module atg_ext_source (
  input  wire logic       clk_sys,
  output logic      [3:0] lines
);
  initial lines = 4'hf;
  task automatic setLine(input int k, input logic v);
    @(posedge clk_sys);
    lines[k] <= v;
  endtask : setLine
  task automatic pulse(input int k);
    setLine(k, 1'b0);
    repeat (6) @(posedge clk_sys);
    lines[k] <= 1'b1;
    repeat (40) @(posedge clk_sys);
  endtask : pulse
endmodule : atg_ext_source

/* tb/atg_timing_test.sv */
`timescale 1ns/1ps
module atg_timing_test;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cOut, cOeN, mark, latchN, hold, dacUpd, convNet;
  logic [3:0] lines;
  int errTotal, checksDone, cyc, holds, marks, lows, dacs, netLows;
  atg_ext_source src (.clk_sys(clk_sys), .lines(lines));
  // net follows the source convert line unless the device drives it
  assign convNet = cOeN ? lines[atg_pkg::SYN_CONV] : cOut;
  atg_timing uut (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .acquisitionTriggerIn(lines[atg_pkg::SYN_TRIG]),
    .conversionGateIn(lines[atg_pkg::SYN_GATE]), .convertRequestIn(convNet),
    .convertRequestOut(cOut), .convertRequestOeN(cOeN),
    .dacUpdateTriggerIn(lines[atg_pkg::SYN_DAC]), .scanConversionMarker(mark),
    .outboundLatchPulseN(latchN), .adcHoldStart(hold), .dacUpdateStrobe(dacUpd));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    holds += (hold === 1'b1);
    marks += (mark === 1'b1);
    lows += (latchN === 1'b0);
    dacs += (dacUpd === 1'b1);
    netLows += (convNet === 1'b0);
    if (cyc == 20000) begin
      errTotal++;
      finalReport();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Wait for pready; the cycle timeout ends the run if it never comes
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic finalReport();
    $display("errors=%0d checks=%0d", errTotal, checksDone);
    if (errTotal == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finalReport
  task automatic run(input logic [31:0] ctl, input logic [31:0] cnt);
    apb(1'b1, atg_pkg::OFF_CTRL, ctl);
    apb(1'b1, atg_pkg::OFF_SCOUNT, cnt);
    apb(1'b1, atg_pkg::OFF_CMD, 32'h1);
  endtask : run
  task automatic testRegsStrobe();
    int l;
    apb(1'b0, atg_pkg::OFF_INTERVAL, 32'h0);
    check(rd, 32'h64);
    apb(1'b0, 8'h18, 32'h0);
    check(lastErr, 1'b1);
    l = lows;
    apb(1'b1, atg_pkg::OFF_STROBE, 32'h0);
    repeat (80) @(posedge clk_sys);
    check(lows - l, atg_pkg::STROBE_CYC_I);
  endtask : testRegsStrobe
  task automatic testExtConv();
    int h, m;
    run(32'h01, 32'h2);
    h = holds;
    m = marks;
    src.pulse(atg_pkg::SYN_CONV);
    repeat (400) @(posedge clk_sys);
    check(holds - h, 1);
    check(marks - m, atg_pkg::SCAN_MARK_CYC_I);
    check(cOeN, 1'b1);
    src.pulse(atg_pkg::SYN_CONV);
    src.pulse(atg_pkg::SYN_CONV);
    check(holds - h, 2);
  endtask : testExtConv
  task automatic testGate();
    int h, m;
    run(32'h00, 32'h5);
    h = holds;
    m = marks;
    src.setLine(atg_pkg::SYN_GATE, 1'b0);
    src.pulse(atg_pkg::SYN_CONV);
    check(holds - h, 0);
    src.setLine(atg_pkg::SYN_GATE, 1'b1);
    src.pulse(atg_pkg::SYN_CONV);
    check(holds - h, 1);
    check(marks - m, 0);
    apb(1'b1, atg_pkg::OFF_CTRL, 32'h08);
    src.pulse(atg_pkg::SYN_CONV);
    check(holds - h, 1);
    apb(1'b1, atg_pkg::OFF_CMD, 32'h2);
  endtask : testGate
  task automatic testIntPace();
    int h, n;
    apb(1'b1, atg_pkg::OFF_INTERVAL, 32'h14);
    h = holds;
    n = netLows;
    run(32'h10, 32'h3);
    repeat (22) @(posedge clk_sys);
    check(holds - h, 1);
    check(cOeN, 1'b0);
    repeat (100) @(posedge clk_sys);
    check(holds - h, 3);
    check(netLows - n, 3 * atg_pkg::CONV_DRIVE_CYC_I);
  endtask : testIntPace
  task automatic testPretrig();
    apb(1'b1, atg_pkg::OFF_CTRL, 32'h05);
    src.pulse(atg_pkg::SYN_TRIG);
    apb(1'b0, atg_pkg::OFF_STATUS, 32'h0);
    check(rd[0], 1'b0);
    src.setLine(atg_pkg::SYN_TRIG, 1'b0);
    apb(1'b1, atg_pkg::OFF_CMD, 32'h1);
    apb(1'b0, atg_pkg::OFF_STATUS, 32'h0);
    check(rd[0], 1'b0);
    src.setLine(atg_pkg::SYN_TRIG, 1'b1);
    apb(1'b1, atg_pkg::OFF_CTRL, 32'h03);
    apb(1'b1, atg_pkg::OFF_SCOUNT, 32'h1);
    src.pulse(atg_pkg::SYN_TRIG);
    src.pulse(atg_pkg::SYN_CONV);
    apb(1'b0, atg_pkg::OFF_STATUS, 32'h0);
    check(rd[1:0], 2'h3);
    check(rd[31:16], 16'h1);
    src.pulse(atg_pkg::SYN_TRIG);
    src.pulse(atg_pkg::SYN_CONV);
    apb(1'b0, atg_pkg::OFF_STATUS, 32'h0);
    check(rd[0], 1'b0);
  endtask : testPretrig
  task automatic testDac();
    int d;
    d = dacs;
    apb(1'b1, atg_pkg::OFF_CTRL, 32'h40);
    src.pulse(atg_pkg::SYN_DAC);
    check(dacs - d, 1);
    apb(1'b1, atg_pkg::OFF_CTRL, 32'h60);
    src.pulse(atg_pkg::SYN_DAC);
    check(dacs - d, 1);
  endtask : testDac
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    testRegsStrobe();
    testExtConv();
    testGate();
    testIntPace();
    testPretrig();
    testDac();
    finalReport();
  end
endmodule : atg_timing_test
